// File: core/mdx_mem_decode.sv
// mdx_mem_decode: program counter, program memory decode, external
// multiplexed memory bus sequencer and register bank decode.
// assumes all inputs synchronous to REF_CLK; ROM_DATA is a plain
// combinational read of ROM_ADDR; straps are stable at reset release.
//
// Overview of operation
// - 16-bit program counter, never register-file addressable
// - lowest 12 bytes hold six interrupt vectors
// - addresses 12 to ROM top read internal ROM
// - outside ROM with ports 0/1: external fetch
// - no ports 0/1: NOPs up to FFFFh, wrap
// - ROM protect blocks code loads to internal ROM
// - ROM protect comes from fixed option strap only
// - port 1 multiplexes low address/data, port 0 high
// - external addressing limited to 16 bits
// - strobes low active plus read/write qualify access
// - external program memory follows internal ROM end
// - external data memory from 4096, up to 60 KB
// - data select on port3 bit4 only when selected
// - data select high for code, low for data loads
// - bank C: compare, data, control at 0..2
// - bank F: config 0, stop recovery B, watchdog F
// - bank 0: ports at 0..3, GPRs 4..F
// - window pointer low nibble picks the bank
// - only addresses 00h..0Fh remapped by a bank
`timescale 1ns/1ps
`default_nettype none

module mdx_mem_decode (
	input  wire logic                   REF_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic                   PORTS01_PRESENT,
	input  wire logic                   ROM_PROTECT_OPT,
	input  wire logic [1:0]             P3M_DM_FIELD,
	input  wire logic                   FETCH_REQ,
	input  wire logic                   PC_LOAD,
	input  wire logic [15:0]            PC_LOAD_ADDR,
	input  wire mdx_pkg::mdx_ld_req_s   LD_REQ,
	output logic                        READY,
	output mdx_pkg::mdx_fetch_rsp_s     FETCH_RSP,
	output mdx_pkg::mdx_ld_rsp_s        LD_RSP,
	output logic [15:0]                 ROM_ADDR,
	input  wire logic [7:0]             ROM_DATA,
	input  wire logic [7:0]             P1_IN,
	output mdx_pkg::mdx_bus_out_s       BUS,
	input  wire logic [7:0]             RWP,
	input  wire logic [7:0]             RF_ADDR,
	output mdx_pkg::mdx_rf_dec_s        RF_DEC
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		mdx_pkg::mdx_state_e     st;
		logic [2:0]              cnt;
		logic [15:0]             pc;
		logic                    straps_ok;
		logic                    ports_present;
		logic                    rom_protect;
		logic                    is_fetch;
		logic                    is_write;
		logic                    is_data;
		logic [15:0]             addr;
		logic [7:0]              wdata;
		logic [7:0]              rdata;
		logic [15:0]             rom_addr;
		mdx_pkg::mdx_region_e    region;
		mdx_pkg::mdx_bus_out_s   bus;
		mdx_pkg::mdx_fetch_rsp_s frsp;
		mdx_pkg::mdx_ld_rsp_s    lrsp;
		mdx_pkg::mdx_rf_dec_s    rf;
	} mdx_core_s;

	mdx_core_s state_r;
	mdx_core_s state_nxt;

	localparam mdx_pkg::mdx_bus_out_s BUS_IDLE = '{
		as_n: 1'b1, ds_n: 1'b1, rw: 1'b1,
		p0_out: 8'h00, p0_oe: 1'b0,
		p1_out: 8'h00, p1_oe: 1'b0,
		dm_n: 1'b1, p34_dm_en: 1'b0
	};

	localparam mdx_core_s STATE_RESET = '{
		st: mdx_pkg::ST_IDLE, cnt: 3'h0, pc: mdx_pkg::PC_RESET,
		straps_ok: 1'b0, ports_present: 1'b0, rom_protect: 1'b0,
		is_fetch: 1'b0, is_write: 1'b0, is_data: 1'b0,
		addr: 16'h0000, wdata: 8'h00, rdata: 8'h00,
		rom_addr: 16'h0000, region: mdx_pkg::RGN_ROM,
		bus: BUS_IDLE,
		frsp: '{valid: 1'b0, data: 8'h00, addr: 16'h0000,
			region: mdx_pkg::RGN_ROM},
		lrsp: '{done: 1'b0, refused: 1'b0, rdata: 8'h00},
		rf: '{tgt: mdx_pkg::TGT_PORT, index: 8'h00}
	};

	////////////////////////////////////////////////////////////////////
	// combinational helpers

	logic        dm_on;
	logic        ld_code;
	logic        ld_in_rom;
	logic        ld_to_prog;
	logic        fetch_in_rom;
	logic        fetch_in_vec;

	always_comb begin
		// data select only exists when port 3 mode picks it
		dm_on        = (P3M_DM_FIELD == mdx_pkg::DM_SEL_CODE);
		ld_code      = (LD_REQ.kind == mdx_pkg::LDK_CODE) ||
			(LD_REQ.kind == mdx_pkg::LDK_CODE_INC);
		ld_in_rom    = (LD_REQ.addr <= mdx_pkg::ROM_LAST);
		// without data select, external data shares program space
		ld_to_prog   = ld_code || !dm_on;
		fetch_in_vec = (state_r.pc <= mdx_pkg::VEC_LAST);
		fetch_in_rom = (state_r.pc <= mdx_pkg::ROM_LAST);
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_nxt = state_r;
		state_nxt.frsp.valid = 1'b0;
		state_nxt.lrsp.done = 1'b0;
		state_nxt.lrsp.refused = 1'b0;
		state_nxt.bus.p34_dm_en = dm_on;
		if (!state_r.straps_ok) begin
			// option pins sampled once after reset, never by software
			state_nxt.ports_present = PORTS01_PRESENT;
			state_nxt.rom_protect = ROM_PROTECT_OPT;
			state_nxt.straps_ok = 1'b1;
		end else begin
			case (state_r.st)
			mdx_pkg::ST_IDLE: begin
				if (PC_LOAD) begin
					// only path into the counter besides stepping and reset to 000Ch
					state_nxt.pc = PC_LOAD_ADDR;
				end else if (LD_REQ.valid) begin
					state_nxt.is_fetch = 1'b0;
					state_nxt.is_write = LD_REQ.wr;
					state_nxt.is_data = !ld_code;
					state_nxt.addr = LD_REQ.addr;
					state_nxt.wdata = LD_REQ.wdata;
					if (state_r.rom_protect && ld_to_prog && ld_in_rom) begin
						state_nxt.lrsp.done = 1'b1;
						state_nxt.lrsp.refused = 1'b1;
					end else if (!ld_code && dm_on &&
						LD_REQ.addr < mdx_pkg::DATA_BASE) begin
						state_nxt.lrsp.done = 1'b1;
						state_nxt.lrsp.refused = 1'b1;
					end else if (ld_to_prog && ld_in_rom) begin
						if (LD_REQ.wr) begin
							// ROM is not writable: the write is dropped
							state_nxt.lrsp.done = 1'b1;
						end else begin
							state_nxt.rom_addr = LD_REQ.addr;
							state_nxt.st = mdx_pkg::ST_ROM;
						end
					end else if (!state_r.ports_present) begin
						state_nxt.lrsp.done = 1'b1;
						state_nxt.lrsp.refused = 1'b1;
					end else begin
						state_nxt.st = mdx_pkg::ST_ADDR;
						state_nxt.cnt = mdx_pkg::SETUP_CYC - 3'h1;
						state_nxt.bus.rw = !LD_REQ.wr;
						state_nxt.bus.p0_out = LD_REQ.addr[15:8];
						state_nxt.bus.p0_oe = 1'b1;
						state_nxt.bus.p1_out = LD_REQ.addr[7:0];
						state_nxt.bus.p1_oe = 1'b1;
						state_nxt.bus.dm_n = !(dm_on && !ld_code);
					end
				end else if (FETCH_REQ) begin
					state_nxt.is_fetch = 1'b1;
					state_nxt.is_write = 1'b0;
					state_nxt.is_data = 1'b0;
					state_nxt.addr = state_r.pc;
					if (fetch_in_rom) begin
						state_nxt.region = fetch_in_vec ?
							mdx_pkg::RGN_VECTOR : mdx_pkg::RGN_ROM;
						state_nxt.rom_addr = state_r.pc;
						state_nxt.st = mdx_pkg::ST_ROM;
					end else if (state_r.ports_present) begin
						// external program space begins right after ROM
						state_nxt.region = mdx_pkg::RGN_EXT;
						state_nxt.st = mdx_pkg::ST_ADDR;
						state_nxt.cnt = mdx_pkg::SETUP_CYC - 3'h1;
						state_nxt.bus.rw = 1'b1;
						state_nxt.bus.p0_out = state_r.pc[15:8];
						state_nxt.bus.p0_oe = 1'b1;
						state_nxt.bus.p1_out = state_r.pc[7:0];
						state_nxt.bus.p1_oe = 1'b1;
						state_nxt.bus.dm_n = 1'b1;
					end else begin
						// counter walks on to FFFFh and rolls to 0000h
						state_nxt.frsp.valid = 1'b1;
						state_nxt.frsp.data = mdx_pkg::NOP_CODE;
						state_nxt.frsp.addr = state_r.pc;
						state_nxt.frsp.region = mdx_pkg::RGN_NOP;
						state_nxt.pc = 16'(state_r.pc + mdx_pkg::PC_STEP);
					end
				end
			end
			mdx_pkg::ST_ROM: begin
				state_nxt.st = mdx_pkg::ST_IDLE;
				if (state_r.is_fetch) begin
					state_nxt.frsp.valid = 1'b1;
					state_nxt.frsp.data = ROM_DATA;
					state_nxt.frsp.addr = state_r.rom_addr;
					state_nxt.frsp.region = state_r.region;
					state_nxt.pc = 16'(state_r.pc + mdx_pkg::PC_STEP);
				end else begin
					state_nxt.lrsp.done = 1'b1;
					state_nxt.lrsp.rdata = ROM_DATA;
				end
			end
			mdx_pkg::ST_ADDR: begin
				// address has stood SETUP_CYC before the strobe falls
				if (state_r.cnt == 3'h0) begin
					state_nxt.st = mdx_pkg::ST_ASTB;
					state_nxt.cnt = mdx_pkg::ASTB_CYC - 3'h1;
					state_nxt.bus.as_n = 1'b0;
				end else begin
					state_nxt.cnt = state_r.cnt - 3'h1;
				end
			end
			mdx_pkg::ST_ASTB: begin
				if (state_r.cnt == 3'h0) begin
					state_nxt.st = mdx_pkg::ST_HOLD;
					state_nxt.cnt = mdx_pkg::HOLD_CYC - 3'h1;
					state_nxt.bus.as_n = 1'b1;
				end else begin
					state_nxt.cnt = state_r.cnt - 3'h1;
				end
			end
			mdx_pkg::ST_HOLD: begin
				// low address held past the strobe's rise for the latch
				if (state_r.cnt == 3'h0) begin
					state_nxt.st = mdx_pkg::ST_DSTB;
					state_nxt.cnt = mdx_pkg::DSTB_CYC - 3'h1;
					state_nxt.bus.ds_n = 1'b0;
					state_nxt.bus.p1_out = state_r.is_write ?
						state_r.wdata : 8'h00;
					state_nxt.bus.p1_oe = state_r.is_write;
				end else begin
					state_nxt.cnt = state_r.cnt - 3'h1;
				end
			end
			mdx_pkg::ST_DSTB: begin
				if (state_r.cnt == 3'h0) begin
					state_nxt.st = mdx_pkg::ST_END;
					state_nxt.cnt = mdx_pkg::END_CYC - 3'h1;
					state_nxt.bus.ds_n = 1'b1;
					// read data sampled on the last strobe cycle
					state_nxt.rdata = P1_IN;
				end else begin
					state_nxt.cnt = state_r.cnt - 3'h1;
				end
			end
			mdx_pkg::ST_END: begin
				if (state_r.cnt == 3'h0) begin
					state_nxt.st = mdx_pkg::ST_IDLE;
					state_nxt.bus = BUS_IDLE;
					state_nxt.bus.p34_dm_en = dm_on;
					if (state_r.is_fetch) begin
						state_nxt.frsp.valid = 1'b1;
						state_nxt.frsp.data = state_r.rdata;
						state_nxt.frsp.addr = state_r.addr;
						state_nxt.frsp.region = mdx_pkg::RGN_EXT;
						state_nxt.pc = 16'(state_r.pc + mdx_pkg::PC_STEP);
					end else begin
						state_nxt.lrsp.done = 1'b1;
						state_nxt.lrsp.rdata = state_r.is_write ?
							8'h00 : state_r.rdata;
					end
				end else begin
					state_nxt.cnt = state_r.cnt - 3'h1;
				end
			end
			default: begin
				state_nxt.st = mdx_pkg::ST_IDLE;
				state_nxt.bus = BUS_IDLE;
			end
			endcase
		end

		// register bank decode, one cycle behind its inputs
		state_nxt.rf.index = RF_ADDR;
		if (RF_ADDR > mdx_pkg::WINDOW_LAST ||
			RWP[3:0] == mdx_pkg::BANK_STD) begin
			if (RF_ADDR <= mdx_pkg::PORT_LAST) begin
				state_nxt.rf.tgt = mdx_pkg::TGT_PORT;
			end else if (RF_ADDR <= mdx_pkg::WINDOW_LAST) begin
				state_nxt.rf.tgt = mdx_pkg::TGT_GPR;
			end else begin
				state_nxt.rf.tgt = mdx_pkg::TGT_STD;
			end
		end else if (RWP[3:0] == mdx_pkg::BANK_SERIAL) begin
			case (RF_ADDR[3:0])
			mdx_pkg::LOC_SP_CMP:  state_nxt.rf.tgt = mdx_pkg::TGT_SP_CMP;
			mdx_pkg::LOC_SP_DATA: state_nxt.rf.tgt = mdx_pkg::TGT_SP_DATA;
			mdx_pkg::LOC_SP_CTRL: state_nxt.rf.tgt = mdx_pkg::TGT_SP_CTRL;
			default:              state_nxt.rf.tgt = mdx_pkg::TGT_RSVD;
			endcase
		end else if (RWP[3:0] == mdx_pkg::BANK_CTRL) begin
			case (RF_ADDR[3:0])
			mdx_pkg::LOC_PCFG:    state_nxt.rf.tgt = mdx_pkg::TGT_PCFG;
			mdx_pkg::LOC_STOPREC: state_nxt.rf.tgt = mdx_pkg::TGT_STOPREC;
			mdx_pkg::LOC_WDOG:    state_nxt.rf.tgt = mdx_pkg::TGT_WDOG;
			default:              state_nxt.rf.tgt = mdx_pkg::TGT_RSVD;
			endcase
		end else begin
			// unimplemented banks still hide the low sixteen bytes
			state_nxt.rf.tgt = mdx_pkg::TGT_RSVD;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers and outputs

	// synchronous reset only; the straps are taken again after each release
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_r <= STATE_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// requests arriving while busy are ignored, not queued: callers must
	// hold off until READY is seen high
	assign READY     = state_r.straps_ok && (state_r.st == mdx_pkg::ST_IDLE);
	assign FETCH_RSP = state_r.frsp;
	assign LD_RSP    = state_r.lrsp;
	assign ROM_ADDR  = state_r.rom_addr;
	assign BUS       = state_r.bus;
	assign RF_DEC    = state_r.rf;

endmodule : mdx_mem_decode

`default_nettype wire

// File: core/mdx_pkg.sv
// mdx_pkg: constants, enumerations and carrier structs for the program
// memory decoder, external bus sequencer and register bank decoder.
// assumes a single 100 MHz clock; all sizes fixed at build time.
package mdx_pkg;

	////////////////////////////////////////////////////////////////////
	// clock and external cycle timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_SETUP_NS    = 20;
	localparam int unsigned T_ASTB_NS     = 30;
	localparam int unsigned T_HOLD_NS     = 10;
	localparam int unsigned T_DSTB_NS     = 40;
	localparam int unsigned T_END_NS      = 10;
	// least times, rounded up to whole cycles
	localparam logic [2:0] SETUP_CYC =
		3'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] ASTB_CYC =
		3'((T_ASTB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] HOLD_CYC =
		3'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] DSTB_CYC =
		3'((T_DSTB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] END_CYC =
		3'((T_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////
	// program and data address map
	localparam logic [15:0] VEC_LAST  = 16'h000B;
	localparam logic [15:0] ROM_LAST  = 16'h0FFF;
	localparam logic [15:0] DATA_BASE = 16'h1000;
	localparam logic [15:0] PC_RESET  = 16'h000C;
	localparam logic [15:0] PC_STEP   = 16'h0001;
	localparam logic [7:0]  NOP_CODE  = 8'hFF;
	localparam logic [1:0]  DM_SEL_CODE = 2'h3;

	////////////////////////////////////////////////////////////////////
	// register window and expanded banks
	localparam logic [3:0] BANK_STD    = 4'h0;
	localparam logic [3:0] BANK_SERIAL = 4'hC;
	localparam logic [3:0] BANK_CTRL   = 4'hF;
	localparam logic [7:0] WINDOW_LAST = 8'h0F;
	localparam logic [7:0] PORT_LAST   = 8'h03;
	localparam logic [3:0] LOC_SP_CMP  = 4'h0;
	localparam logic [3:0] LOC_SP_DATA = 4'h1;
	localparam logic [3:0] LOC_SP_CTRL = 4'h2;
	localparam logic [3:0] LOC_PCFG    = 4'h0;
	localparam logic [3:0] LOC_STOPREC = 4'hB;
	localparam logic [3:0] LOC_WDOG    = 4'hF;

	////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ROM  = 7'h02,
		ST_ADDR = 7'h04,
		ST_ASTB = 7'h08,
		ST_HOLD = 7'h10,
		ST_DSTB = 7'h20,
		ST_END  = 7'h40
	} mdx_state_e;

	typedef enum logic [3:0] {
		RGN_VECTOR = 4'h1,
		RGN_ROM    = 4'h2,
		RGN_EXT    = 4'h4,
		RGN_NOP    = 4'h8
	} mdx_region_e;

	typedef enum logic [1:0] {
		LDK_CODE     = 2'h0,
		LDK_CODE_INC = 2'h1,
		LDK_EXT      = 2'h2,
		LDK_EXT_INC  = 2'h3
	} mdx_ld_kind_e;

	typedef enum logic [3:0] {
		TGT_STD     = 4'h0,
		TGT_PORT    = 4'h1,
		TGT_GPR     = 4'h2,
		TGT_SP_CMP  = 4'h3,
		TGT_SP_DATA = 4'h4,
		TGT_SP_CTRL = 4'h5,
		TGT_PCFG    = 4'h6,
		TGT_STOPREC = 4'h7,
		TGT_WDOG    = 4'h8,
		TGT_RSVD    = 4'h9
	} mdx_rf_tgt_e;

	////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic         valid;
		mdx_ld_kind_e kind;
		logic [15:0]  addr;
		logic         wr;
		logic [7:0]   wdata;
	} mdx_ld_req_s;

	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
		logic [15:0] addr;
		mdx_region_e region;
	} mdx_fetch_rsp_s;

	typedef struct packed {
		logic       done;
		logic       refused;
		logic [7:0] rdata;
	} mdx_ld_rsp_s;

	typedef struct packed {
		logic       as_n;
		logic       ds_n;
		logic       rw;
		logic [7:0] p0_out;
		logic       p0_oe;
		logic [7:0] p1_out;
		logic       p1_oe;
		logic       dm_n;
		logic       p34_dm_en;
	} mdx_bus_out_s;

	typedef struct packed {
		mdx_rf_tgt_e tgt;
		logic [7:0]  index;
	} mdx_rf_dec_s;

endpackage : mdx_pkg

// File: verif/mdx_ext_mem.sv
// mdx_ext_mem: behavioural external program and data memory.
// assumes the decoder's bus struct; answers within the strobe.
`timescale 1ns/1ps
`default_nettype none
module mdx_ext_mem (
	input  wire logic                  clk,
	input  wire mdx_pkg::mdx_bus_out_s bus,
	output logic [7:0]                 p1_in
);
	logic [7:0]  mem [65536];
	logic [15:0] addr_r;
	logic [7:0]  rd_r;
	function automatic logic [7:0] fill(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction : fill
	// unwritten locations read back a pattern tied to their address
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = fill(16'(i));
	end
	// a real latch takes the low byte while the strobe falls
	always @(negedge bus.as_n) addr_r = {bus.p0_out, bus.p1_out};
	always @(posedge clk) begin
		if (!bus.ds_n && !bus.rw)
			mem[addr_r] <= bus.p1_out;
		rd_r <= mem[addr_r];
	end
	// released port shows the inverse, so a stale sample cannot match
	assign p1_in = (!bus.ds_n && bus.rw) ? rd_r : ~rd_r;
endmodule : mdx_ext_mem
`default_nettype wire

// File: verif/mdx_mem_decode_properties.sv
// mdx_props: port-level checks of the decoder's bus, fetch and banks.
// assumes it is bound into mdx_mem_decode; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module mdx_props (
	input wire logic                    REF_CLK,
	input wire logic                    SYS_RST,
	input wire logic                    PORTS01_PRESENT,
	input wire logic [1:0]              P3M_DM_FIELD,
	input wire mdx_pkg::mdx_fetch_rsp_s FETCH_RSP,
	input wire mdx_pkg::mdx_bus_out_s   BUS,
	input wire logic [7:0]              RWP,
	input wire logic [7:0]              RF_ADDR,
	input wire mdx_pkg::mdx_rf_dec_s    RF_DEC
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////////
	sequence s_astb;
		!BUS.as_n [*3] ##1 (BUS.as_n && BUS.ds_n);
	endsequence
	sequence s_dstb;
		!BUS.ds_n [*4] ##1 BUS.ds_n;
	endsequence
	a_strobe_order: assert property (
		$fell(BUS.as_n) |-> s_astb ##1 s_dstb)
		else $error("strobe order wrong");
	a_addr_held: assert property (
		!BUS.as_n |-> $stable({BUS.p0_out, BUS.p1_out}) &&
		BUS.p0_oe && BUS.p1_oe) else $error("address moved under strobe");
	a_read_release: assert property (
		!BUS.ds_n && BUS.rw |-> !BUS.p1_oe && BUS.p0_oe)
		else $error("read bus not released");
	a_write_drive: assert property (
		!BUS.ds_n && !BUS.rw |-> BUS.p1_oe)
		else $error("write data not driven");
	a_bus_quiet: assert property (
		!PORTS01_PRESENT |-> BUS.as_n && BUS.ds_n && !BUS.p0_oe)
		else $error("bus used w/o ports");
	a_dm_pin_off: assert property (
		P3M_DM_FIELD != mdx_pkg::DM_SEL_CODE &&
		$past(P3M_DM_FIELD) != mdx_pkg::DM_SEL_CODE |-> !BUS.p34_dm_en)
		else $error("select pin enabled");
	a_vec_region: assert property (FETCH_RSP.valid &&
		FETCH_RSP.addr <= mdx_pkg::VEC_LAST |->
		FETCH_RSP.region == mdx_pkg::RGN_VECTOR) else $error("vector region");
	a_rom_region: assert property (FETCH_RSP.valid &&
		FETCH_RSP.addr > mdx_pkg::VEC_LAST &&
		FETCH_RSP.addr <= mdx_pkg::ROM_LAST |->
		FETCH_RSP.region == mdx_pkg::RGN_ROM) else $error("rom region");
	a_ext_region: assert property (FETCH_RSP.valid &&
		FETCH_RSP.addr > mdx_pkg::ROM_LAST |-> FETCH_RSP.region ==
		(PORTS01_PRESENT ? mdx_pkg::RGN_EXT : mdx_pkg::RGN_NOP))
		else $error("outside rom region");
	a_nop_byte: assert property (FETCH_RSP.valid &&
		FETCH_RSP.region == mdx_pkg::RGN_NOP |->
		FETCH_RSP.data == mdx_pkg::NOP_CODE) else $error("nop byte");
	a_rf_upper: assert property (!$past(SYS_RST) &&
		$past(RF_ADDR) > mdx_pkg::WINDOW_LAST |-> RF_DEC.tgt ==
		mdx_pkg::TGT_STD && RF_DEC.index == $past(RF_ADDR))
		else $error("upper register remapped");
	a_rf_ports: assert property (!$past(SYS_RST) &&
		$past(RWP[3:0]) == mdx_pkg::BANK_STD &&
		$past(RF_ADDR) <= mdx_pkg::PORT_LAST |->
		RF_DEC.tgt == mdx_pkg::TGT_PORT) else $error("port decode");
endmodule : mdx_props
`default_nettype wire

// File: verif/tb_memory_space_decode_ext_bus.sv
// tb_memory_space_decode_ext_bus: self-checking bench of the decoder.
// assumes mdx_pkg, mdx_mem_decode, mdx_props and mdx_ext_mem.
`timescale 1ns/1ps
`default_nettype none
module tb_memory_space_decode_ext_bus;
	logic        clk, rst, ports, prot, fetch_req, pc_load, dm_seen;
	logic [1:0]  p3m;
	logic [15:0] pc_addr, rom_addr;
	logic [7:0]  rom_data, p1_in, rwp, rf_addr;
	logic        ready;
	int          err_total, n_compared;
	mdx_pkg::mdx_ld_req_s    ld_req;
	mdx_pkg::mdx_fetch_rsp_s fetch_rsp;
	mdx_pkg::mdx_ld_rsp_s    ld_rsp;
	mdx_pkg::mdx_bus_out_s   bus;
	mdx_pkg::mdx_rf_dec_s    rf_dec;

	mdx_mem_decode dut (.REF_CLK(clk), .SYS_RST(rst),
		.PORTS01_PRESENT(ports), .ROM_PROTECT_OPT(prot),
		.P3M_DM_FIELD(p3m), .FETCH_REQ(fetch_req), .PC_LOAD(pc_load),
		.PC_LOAD_ADDR(pc_addr), .LD_REQ(ld_req), .READY(ready),
		.FETCH_RSP(fetch_rsp), .LD_RSP(ld_rsp), .ROM_ADDR(rom_addr),
		.ROM_DATA(rom_data), .P1_IN(p1_in), .BUS(bus), .RWP(rwp),
		.RF_ADDR(rf_addr), .RF_DEC(rf_dec));
	mdx_ext_mem u_mem (.clk(clk), .bus(bus), .p1_in(p1_in));

	function automatic logic [7:0] rom(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction : rom
	function automatic logic [7:0] fill(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction : fill
	assign rom_data = rom(rom_addr);
	always @(posedge clk)
		if (!bus.ds_n)
			dm_seen <= bus.dm_n;
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test();
		if (err_total == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic do_reset(input logic p, input logic q);
		@(posedge clk) rst <= 1'b1;
		ports <= p;
		prot <= q;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// first edge after release only takes the straps
		#1;
		check(ready, 1'b0);
		check({bus.as_n, bus.ds_n, bus.p0_oe, bus.p1_oe}, 4'hC);
		@(posedge clk);
		#1;
		check(ready, 1'b1);
	endtask : do_reset
	// ends on the edge after READY was seen high; caller drives there
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ready !== 1'b1 && n < 30);
		check(ready, 1'b1);
		@(posedge clk);
	endtask : wait_ready
	// called at the take edge: a one-cycle answer stands right after it
	task automatic await(input bit ld, input int lat);
		int n;
		n = 1;
		#1;
		while ((ld ? ld_rsp.done : fetch_rsp.valid) !== 1'b1 &&
			n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n, lat);
	endtask : await
	task automatic fetch(input logic [15:0] a, input logic [3:0] rg,
		input logic [7:0] d, input int lat);
		wait_ready();
		fetch_req <= 1'b1;
		@(posedge clk) fetch_req <= 1'b0;
		await(1'b0, lat);
		check({fetch_rsp.addr, fetch_rsp.region, fetch_rsp.data},
			{a, rg, d});
	endtask : fetch
	task automatic pc_set(input logic [15:0] a);
		wait_ready();
		pc_load <= 1'b1;
		pc_addr <= a;
		@(posedge clk) pc_load <= 1'b0;
	endtask : pc_set
	task automatic load(input logic [1:0] k, input logic [15:0] a,
		input logic w, input logic [7:0] wd, input logic [8:0] e,
		input int lat);
		wait_ready();
		ld_req <= {1'b1, k, a, w, wd};
		@(posedge clk) ld_req.valid <= 1'b0;
		await(1'b1, lat);
		check({ld_rsp.refused,
			(w || ld_rsp.refused) ? 8'h00 : ld_rsp.rdata}, e);
	endtask : load
	////////////////////////////////////////////////////////////////////
	task automatic t_fetch_map();
		fetch(16'h000C, 4'h2, rom(16'h000C), 2);
		fetch(16'h000D, 4'h2, rom(16'h000D), 2);
		pc_set(16'h000B);
		fetch(16'h000B, 4'h1, rom(16'h000B), 2);
		pc_set(16'h0FFF);
		fetch(16'h0FFF, 4'h2, rom(16'h0FFF), 2);
		fetch(16'h1000, 4'h4, fill(16'h1000), 12);
		pc_set(16'hFFFF);
		fetch(16'hFFFF, 4'h4, fill(16'hFFFF), 12);
		fetch(16'h0000, 4'h1, rom(16'h0000), 2);
	endtask : t_fetch_map
	task automatic t_nop();
		do_reset(1'b0, 1'b0);
		pc_set(16'h1000);
		fetch(16'h1000, 4'h8, 8'hFF, 1);
		pc_set(16'hFFFF);
		fetch(16'hFFFF, 4'h8, 8'hFF, 1);
		fetch(16'h0000, 4'h1, rom(16'h0000), 2);
		load(2'h2, 16'h2000, 1'b0, 8'h00, 9'h100, 1);
	endtask : t_nop
	task automatic t_protect();
		do_reset(1'b1, 1'b1);
		for (int k = 0; k < 4; k++)
			load(2'(k), 16'h0100, 1'b0, 8'h00, 9'h100, 1);
		@(posedge clk) p3m <= 2'h3;
		load(2'h2, 16'h0800, 1'b0, 8'h00, 9'h100, 1);
		load(2'h0, 16'h3000, 1'b0, 8'h00,
			{1'b0, fill(16'h3000)}, 12);
		check(dm_seen, 1'b1);
		check(bus.p34_dm_en, 1'b1);
	endtask : t_protect
	task automatic t_data_mem();
		do_reset(1'b1, 1'b0);
		load(2'h1, 16'h0100, 1'b0, 8'h00, {1'b0, rom(16'h0100)}, 2);
		// a write into ROM is answered at once and has no effect
		load(2'h0, 16'h0200, 1'b1, 8'h55, 9'h000, 1);
		load(2'h3, 16'h2000, 1'b1, 8'hA7, 9'h000, 12);
		check(dm_seen, 1'b0);
		load(2'h2, 16'h2000, 1'b0, 8'h00, 9'h0A7, 12);
	endtask : t_data_mem
	task automatic t_rf();
		logic [19:0] tbl [14] = '{20'h00021, 20'h00072, 20'h0C003,
			20'h0C014, 20'h0C025, 20'h0C059, 20'h0F006, 20'h0F0B7,
			20'h0F0F8, 20'h0F039, 20'h3C200, 20'h05099, 20'hFF0F8,
			20'h0CFF0};
		foreach (tbl[i]) begin
			@(posedge clk) rwp <= tbl[i][19:12];
			rf_addr <= tbl[i][11:4];
			@(posedge clk);
			#1;
			check({rf_dec.tgt, rf_dec.index},
				{tbl[i][3:0], tbl[i][11:4]});
		end
	endtask : t_rf
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		err_total++;
		stop_test();
	end
	initial begin
		{rst, ports, prot, fetch_req, pc_load} = 5'h10;
		{p3m, pc_addr, rwp, rf_addr} = '0;
		ld_req = '0;
		err_total = 0;
		n_compared = 0;
		do_reset(1'b1, 1'b0);
		t_fetch_map();
		t_rf();
		t_nop();
		t_protect();
		t_data_mem();
		stop_test();
	end
endmodule : tb_memory_space_decode_ext_bus

bind mdx_mem_decode mdx_props u_props (.REF_CLK(REF_CLK),
	.SYS_RST(SYS_RST), .PORTS01_PRESENT(PORTS01_PRESENT),
	.P3M_DM_FIELD(P3M_DM_FIELD), .FETCH_RSP(FETCH_RSP), .BUS(BUS),
	.RWP(RWP), .RF_ADDR(RF_ADDR), .RF_DEC(RF_DEC));
`default_nettype wire
